/* File: src/sfg_defines.vh */
// register offsets, field positions and reset values of the clock/frame sync generator
// assumes inclusion by the generator files only
`ifndef SFG_DEFINES_VH
`define SFG_DEFINES_VH

`define SFG_UNITS 4
`define SFG_ADDR_W 8
// per-unit register block: unit index in addr[5:4], register in addr[3:2]
`define SFG_OFS_CTL0 2'h0
`define SFG_OFS_CTL1 2'h1
`define SFG_OFS_PW 2'h2
`define SFG_OFS_SYNC 2'h3
`define SFG_OFS_STATUS 8'h40
`define SFG_UNIT_SPAN 8'h40

// first control register
`define SFG_DIV_MSB 19
`define SFG_PHASE_MSB 29
`define SFG_PHASE_LSB 20
`define SFG_CTL0_FSEN 30
`define SFG_CTL0_CLKEN 31
// second control register
`define SFG_CTL1_FSEXT 30
`define SFG_CTL1_CLKEXT 31
// pulse width register, bypass meaning
`define SFG_PW_MSB 15
`define SFG_PW_STROBE 0
`define SFG_PW_INVERT 1
// sync register
`define SFG_SYNC_TRIGEN 0
`define SFG_SYNC_CLKPCLK 1
`define SFG_SYNC_FSPCLK 2
`define SFG_SYNC_ROUTE_MSB 8
`define SFG_SYNC_ROUTE_LSB 4
// routing codes that would feed a unit's own clock back to itself
`define SFG_ROUTE_LOOP_A 5'h1c
`define SFG_ROUTE_LOOP_B 5'h1d

`define SFG_RESET_WORD 32'h00000000

`endif

/* File: src/sfg_generator.v */
// four-unit serial clock and frame sync generator with an apb register slave
// assumes apb master on clk; crystal, external, trigger and bypass inputs are asynchronous pins
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sfg_defines.vh"

module sfg_generator (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire crystal_clock_in,
  input wire [3:0] external_source_in,
  input wire [3:0] external_trigger_in,
  input wire bypass_frame_in_unit_a,
  input wire bypass_frame_in_unit_b,
  input wire bypass_frame_in_unit_c,
  input wire bypass_frame_in_unit_d,
  output wire [3:0] serial_clock_out,
  output wire [3:0] frame_sync_out,
  output wire [1:0] periphClockOut,
  output wire [1:0] periphFrameOut
);

  ////////////////////////////////////////////////////////////////////////////////
  // register file

  reg [31:0] ctl0_reg [0:3];
  reg [31:0] ctl1_reg [0:3];
  reg [31:0] pw_reg [0:3];
  reg [31:0] sync_reg [0:3];
  reg [31:0] prdata_next;
  reg pslverr_next;
  integer i;

  wire [3:0] unitClk;
  wire [3:0] unitFs;
  wire [3:0] unitArmed;
  reg [11:0] status_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  // address decode used by both the read and the write path
  function decodeHit;
    input [7:0] addr;
    begin
      decodeHit = (addr < `SFG_UNIT_SPAN) && (addr[1:0] == 2'b00);
    end
  endfunction

  wire [1:0] selUnit = paddr[5:4];
  wire [1:0] selReg = paddr[3:2];
  wire isStatus = (paddr == `SFG_OFS_STATUS);
  wire setup = psel & ~penable;
  wire doWrite = psel & penable & pready & pwrite & decodeHit(paddr);

  always @* begin
    prdata_next = 32'h00000000;
    pslverr_next = 1'b0;
    if (isStatus) begin
      prdata_next = {20'h00000, status_reg};
    end else if (decodeHit(paddr)) begin
      case (selReg)
        `SFG_OFS_CTL0: prdata_next = ctl0_reg[selUnit];
        `SFG_OFS_CTL1: prdata_next = ctl1_reg[selUnit];
        `SFG_OFS_PW: prdata_next = pw_reg[selUnit];
        `SFG_OFS_SYNC: prdata_next = sync_reg[selUnit];
        default: prdata_next = 32'h00000000;
      endcase
    end else begin
      pslverr_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb answer

  // answer is prepared in the setup cycle so the access phase never waits
  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= pslverr_next;
      prdata <= pwrite ? 32'h00000000 : prdata_next;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status snapshot

  // taken every cycle; a read shows the unit outputs one cycle old
  always @(posedge clk) begin
    if (rst) begin
      status_reg <= 12'h000;
    end else begin
      status_reg <= {unitArmed, unitFs, unitClk};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register write

  // unmapped and status writes never reach this block
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < `SFG_UNITS; i = i + 1) begin
        ctl0_reg[i] <= `SFG_RESET_WORD;
        ctl1_reg[i] <= `SFG_RESET_WORD;
        pw_reg[i] <= `SFG_RESET_WORD;
        sync_reg[i] <= `SFG_RESET_WORD;
      end
    end else if (doWrite) begin
      case (selReg)
        `SFG_OFS_CTL0: ctl0_reg[selUnit] <= pwdata;
        `SFG_OFS_CTL1: ctl1_reg[selUnit] <= pwdata;
        `SFG_OFS_PW: pw_reg[selUnit] <= pwdata;
        `SFG_OFS_SYNC: sync_reg[selUnit] <= pwdata;
        default: ctl0_reg[selUnit] <= ctl0_reg[selUnit];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  wire [3:0] bypassPins = {bypass_frame_in_unit_d, bypass_frame_in_unit_c,
                           bypass_frame_in_unit_b, bypass_frame_in_unit_a};
  wire [12:0] pinRaw = {crystal_clock_in, bypassPins, external_trigger_in,
                        external_source_in};
  reg [12:0] pinMeta_reg;
  reg [12:0] pinSync_reg;
  reg [12:0] pinPrev_reg;
  reg pclkHalf_reg;

  // external inputs can only be followed at up to half of clk
  always @(posedge clk) begin
    if (rst) begin
      pinMeta_reg <= 13'h0000;
      pinSync_reg <= 13'h0000;
      pinPrev_reg <= 13'h0000;
      pclkHalf_reg <= 1'b0;
    end else begin
      pinMeta_reg <= pinRaw;
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg;
      pclkHalf_reg <= ~pclkHalf_reg;
    end
  end

  wire [12:0] pinRise = pinSync_reg & ~pinPrev_reg;
  wire [12:0] pinFall = ~pinSync_reg & pinPrev_reg;
  // peripheral clock source runs at half of clk so every edge is a flop edge
  wire pclkRise = ~pclkHalf_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // the four units

  // source decode shared by the clock and frame sync levels and edges of each unit
  function pickSource;
    input usePclk;
    input useExt;
    input pclkVal;
    input extVal;
    input xtalVal;
    begin
      if (usePclk) begin
        pickSource = pclkVal;
      end else if (useExt) begin
        pickSource = extVal;
      end else begin
        pickSource = xtalVal;
      end
    end
  endfunction

  // routing codes that would hand a unit its own clock back
  function isLoopCode;
    input integer unitIdx;
    input [4:0] code;
    begin
      if (unitIdx == 0) begin
        isLoopCode = (code == `SFG_ROUTE_LOOP_A);
      end else if (unitIdx == 1) begin
        isLoopCode = (code == `SFG_ROUTE_LOOP_B);
      end else begin
        isLoopCode = 1'b0;
      end
    end
  endfunction

  genvar u;
  generate
    for (u = 0; u < `SFG_UNITS; u = u + 1) begin : g_unit
      wire [31:0] c0 = ctl0_reg[u];
      wire [31:0] c1 = ctl1_reg[u];
      wire [31:0] sy = sync_reg[u];
      wire [4:0] route = sy[`SFG_SYNC_ROUTE_MSB:`SFG_SYNC_ROUTE_LSB];
      // a unit may never be fed its own clock, so that code reads low
      wire loopCode = isLoopCode(u, route);
      wire extLevel = pinSync_reg[u] & ~loopCode;
      wire extRise = pinRise[u] & ~loopCode;
      wire extFall = pinFall[u] & ~loopCode;
      wire clkPclk = sy[`SFG_SYNC_CLKPCLK];
      wire fsPclk = sy[`SFG_SYNC_FSPCLK];
      wire clkExt = c1[`SFG_CTL1_CLKEXT];
      wire fsExt = c1[`SFG_CTL1_FSEXT];
      // source select: peripheral clock wins, then external, else crystal
      wire clkLevel = pickSource(clkPclk, clkExt, pclkHalf_reg, extLevel,
                                 pinSync_reg[12]);
      wire clkRise = pickSource(clkPclk, clkExt, pclkRise, extRise,
                                pinRise[12]);
      wire fsLevel = pickSource(fsPclk, fsExt, pclkHalf_reg, extLevel,
                                pinSync_reg[12]);
      wire fsRise = pickSource(fsPclk, fsExt, pclkRise, extRise,
                               pinRise[12]);
      wire fsFall = pickSource(fsPclk, fsExt, pclkHalf_reg, extFall,
                               pinFall[12]);
      wire [19:0] phase = {c0[`SFG_PHASE_MSB:`SFG_PHASE_LSB],
                           c1[`SFG_PHASE_MSB:`SFG_PHASE_LSB]};

      sfg_unit u_sfg_unit (
        .clk(clk),
        .rst(rst),
        .clkEn(c0[`SFG_CTL0_CLKEN]),
        .fsEn(c0[`SFG_CTL0_FSEN]),
        .clkLevel(clkLevel),
        .clkRise(clkRise),
        .fsLevel(fsLevel),
        .fsRise(fsRise),
        .fsFall(fsFall),
        .clkDiv(c1[`SFG_DIV_MSB:0]),
        .frame_divisor(c0[`SFG_DIV_MSB:0]),
        .phase(phase),
        .pulseWidth(pw_reg[u][`SFG_PW_MSB:0]),
        .trigEn(sy[`SFG_SYNC_TRIGEN]),
        .trigRise(pinRise[4 + u]),
        .bypassLevel(pinSync_reg[8 + u]),
        .bypassRise(pinRise[8 + u]),
        .clkOut(unitClk[u]),
        .fsOut(unitFs[u]),
        .trigArmed(unitArmed[u])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  reg [3:0] sckPin_reg;
  reg [3:0] fsPin_reg;

  // retimed here so every pin of the block leaves from a flop of this module
  always @(posedge clk) begin
    if (rst) begin
      sckPin_reg <= 4'h0;
      fsPin_reg <= 4'h0;
    end else begin
      sckPin_reg <= unitClk;
      fsPin_reg <= unitFs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin and peripheral outputs

  assign serial_clock_out = sckPin_reg;
  assign frame_sync_out = fsPin_reg;
  // only the first two units feed other peripherals directly
  assign periphClockOut = sckPin_reg[1:0];
  assign periphFrameOut = fsPin_reg[1:0];

endmodule // sfg_generator
`default_nettype wire

/* File: src/sfg_unit.v */
// one clock / frame sync generator unit
// assumes all inputs already synchronous to clk, edges given as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "sfg_defines.vh"

module sfg_unit (
  input wire clk,
  input wire rst,
  input wire clkEn,
  input wire fsEn,
  input wire clkLevel,
  input wire clkRise,
  input wire fsLevel,
  input wire fsRise,
  input wire fsFall,
  input wire [19:0] clkDiv,
  input wire [19:0] frame_divisor,
  input wire [19:0] phase,
  input wire [15:0] pulseWidth,
  input wire trigEn,
  input wire trigRise,
  input wire bypassLevel,
  input wire bypassRise,
  output reg clkOut,
  output reg fsOut,
  output reg trigArmed
);

  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_HIGH = 2'd2;

  reg [19:0] clkCnt_reg;
  reg [19:0] fsCnt_reg;
  reg [1:0] shotState_reg;
  reg [1:0] shotEdges_reg;
  wire clkBypass = (clkDiv < 20'h00002);
  wire fsBypass = (frame_divisor < 20'h00002);
  wire strobe = pulseWidth[`SFG_PW_STROBE];
  wire invert = pulseWidth[`SFG_PW_INVERT];
  wire [19:0] fsStart = (phase == 20'h00000) ? 20'h00000 : frame_divisor - phase;
  wire [19:0] fsWidth = (pulseWidth == 16'h0000) ? {1'b0, frame_divisor[19:1]} : {4'h0, pulseWidth};
  wire fsRun = fsEn & (~trigEn | trigArmed);
  wire shotArm = invert ? fsFall : fsRise;

  ////////////////////////////////////////////////////////////////////////////////
  // bit clock divider
  always @(posedge clk) begin
    if (rst || !clkEn) begin
      clkCnt_reg <= 20'h00000;
      clkOut <= 1'b0;
    end else if (clkBypass) begin
      clkOut <= clkLevel;
    end else if (clkRise) begin
      clkOut <= (clkCnt_reg < {1'b0, clkDiv[19:1]});
      clkCnt_reg <= (clkCnt_reg >= clkDiv - 20'h00001) ? 20'h00000 : clkCnt_reg + 20'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // trigger arming: held until the frame sync enable or the trigger enable is cleared
  always @(posedge clk) begin
    if (rst || !fsEn || !trigEn) begin
      trigArmed <= 1'b0;
    end else if (trigRise) begin
      trigArmed <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame sync: divider, phase, width, bypass and one-shot
  always @(posedge clk) begin
    if (rst || !fsEn) begin
      fsCnt_reg <= 20'h00000;
      fsOut <= 1'b0;
      shotState_reg <= ST_IDLE;
      shotEdges_reg <= 2'd0;
    end else if (fsBypass) begin
      fsCnt_reg <= fsStart;
      if (!strobe) begin
        fsOut <= bypassLevel ^ invert;
      end else begin
        // one-shot ignores the dividers and tracks the bypass input
        case (shotState_reg)
          ST_IDLE: begin
            fsOut <= 1'b0;
            shotEdges_reg <= 2'd0;
            if (shotArm) begin
              shotState_reg <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (bypassRise) begin
              if (shotEdges_reg == 2'd1) begin
                shotState_reg <= ST_HIGH;
                fsOut <= 1'b1;
              end else begin
                shotEdges_reg <= shotEdges_reg + 2'd1;
              end
            end
          end
          ST_HIGH: begin
            if (bypassRise) begin
              fsOut <= 1'b0;
              shotState_reg <= ST_IDLE;
            end
          end
          default: begin
            shotState_reg <= ST_IDLE;
          end
        endcase
      end
    end else if (!fsRun) begin
      fsCnt_reg <= fsStart;
      fsOut <= 1'b0;
    end else if (fsRise) begin
      fsOut <= (fsCnt_reg < fsWidth);
      fsCnt_reg <= (fsCnt_reg >= frame_divisor - 20'h00001) ? 20'h00000 : fsCnt_reg + 20'h00001;
    end
  end

endmodule // sfg_unit
`default_nettype wire

/* File: test/sfg_generator_chk.sv */
// checker: apb answer timing and output relations of the generator top
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sfg_generator_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] serial_clock_out,
  input wire logic [3:0] frame_sync_out,
  input wire logic [1:0] periphClockOut,
  input wire logic [1:0] periphFrameOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence bad_s;
    setup_s ##0 (paddr >= 8'h44 || paddr[1:0] != 2'h0);
  endsequence
  a_ready_next: assert property (setup_s |=> pready)
    else $error("ready missing after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_bad_addr: assert property (bad_s ##0 !pwrite |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_good_addr: assert property (setup_s ##0 paddr < 8'h44 ##0 paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  a_data_hold: assert property (!setup_s |=> $stable(prdata))
    else $error("read data moved outside setup");
  a_periph_copy: assert property (periphClockOut == serial_clock_out[1:0] &&
    periphFrameOut == frame_sync_out[1:0]) else $error("peripheral copy differs");
  a_reset_quiet: assert property ($past(rst) |-> serial_clock_out == 4'h0 &&
    frame_sync_out == 4'h0) else $error("outputs not low after reset");
  a_status_clean: assert property (setup_s ##0 !pwrite ##0 paddr == 8'h40 |=>
    prdata[31:12] == 20'h0) else $error("status spare bits set");
endmodule // sfg_generator_chk
bind sfg_generator sfg_generator_chk u_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_clock_out(serial_clock_out), .frame_sync_out(frame_sync_out),
  .periphClockOut(periphClockOut), .periphFrameOut(periphFrameOut));
`default_nettype wire

/* File: test/sfg_generator_tb.sv */
// bench for the four-unit clock and frame sync generator
// assumes apb slave answers with pready; port model watches the unit chosen by sel
`timescale 1ns/1ps
`default_nettype none
module sfg_generator_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, together;
  logic xtal = 1'b0;
  logic [3:0] extSrc = 4'h0;
  logic [3:0] extTrig = 4'h0;
  logic [3:0] bypIn = 4'h0;
  logic [3:0] sck, fs;
  logic [1:0] sel = 2'h0;
  logic clr = 1'b0;
  logic [15:0] sckHi, sckLo, fsHi, fsLo;
  logic [31:0] msk [4] = '{32'hffffffff, 32'hffffffff, 32'h0000ffff, 32'h000001f7};
  int err_count = 0;
  int checks_done = 0;
  int seed = 32'h2050;
  always #50 clk = ~clk;
  always @(posedge clk) xtal <= ~xtal;
  ////////////////////////////////////////////////////////////////////////////
  sfg_generator u_sfg_generator (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystal_clock_in(xtal), .external_source_in(extSrc),
    .external_trigger_in(extTrig), .bypass_frame_in_unit_a(bypIn[0]),
    .bypass_frame_in_unit_b(bypIn[1]), .bypass_frame_in_unit_c(bypIn[2]),
    .bypass_frame_in_unit_d(bypIn[3]), .serial_clock_out(sck), .frame_sync_out(fs),
    .periphClockOut(), .periphFrameOut());
  sfg_port_model u_sfg_port_model (.clk(clk), .clr(clr), .sck(sck[sel]), .fs(fs[sel]),
    .sckHi(sckHi), .sckLo(sckLo), .fsHi(fsHi), .fsLo(fsLo), .together(together));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ra(input int u, input int r);
    return 8'(u * 16 + r * 4);
  endfunction
  // width 0 falls back to half the divisor, rounded down; two clk per source period
  function automatic logic [31:0] hiExp(input logic [31:0] d, input logic [31:0] w);
    return (w != 0) ? w << 1 : (d >> 1) << 1;
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (n >= 16) begin
      err_count++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d, wd, w;
    logic seen;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, ra(i / 4, i % 4), 32'h0);
      chk("reset value", 32'h0, rd);
      w = $random(seed) & msk[i % 4];
      apb(1'b1, ra(i / 4, i % 4), w);
      apb(1'b0, ra(i / 4, i % 4), 32'h0);
      chk("readback", w, rd & msk[i % 4]);
      apb(1'b1, ra(i / 4, i % 4), 32'h0);
    end
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, (k == 0) ? 8'h44 : (k == 1) ? 8'h06 : 8'h40, 32'h0);
      chk("error flag", {31'h0, k < 2}, {31'h0, err});
    end
    // both dividers from peripheral clock, equal divisors, one enabling write
    for (int i = 0; i < 8; i++) begin
      clr <= 1'b1;
      sel <= 2'(i);
      d = 32'h2 + ($random(seed) & 32'h7);
      wd = ($random(seed) & 32'hf) % d;
      apb(1'b1, ra(i % 4, 3), 32'h6);
      clr <= 1'b0;
      apb(1'b1, ra(i % 4, 2), wd);
      apb(1'b1, ra(i % 4, 1), d);
      apb(1'b1, ra(i % 4, 0), 32'hc0000000 | d);
      repeat (6 * d + 8) @(posedge clk);
      chk("clock high", hiExp(d, 0), {16'h0, sckHi});
      chk("clock low", 2 * d - hiExp(d, 0), {16'h0, sckLo});
      chk("frame high", hiExp(d, wd), {16'h0, fsHi});
      chk("frame period", 2 * d, 32'(fsHi) + 32'(fsLo));
      chk("edges together", 32'h1, {31'h0, together});
      apb(1'b1, ra(i % 4, 0), 32'h0);
      repeat (4) @(posedge clk);
      chk("disabled outputs", 32'h0, {30'h0, sck[i % 4], fs[i % 4]});
    end
    apb(1'b1, ra(1, 0), 32'h40000000);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ra(1, 2), {30'h0, k[1], 1'b0});
      bypIn <= {4{k[0]}};
      repeat (8) @(posedge clk);
      chk("bypass frame", {31'h0, k[0] ^ k[1]}, {31'h0, fs[1]});
    end
    // one-shot: high one bypass period, high again two bypass periods later
    clr <= 1'b1;
    sel <= 2'h1;
    apb(1'b1, ra(1, 3), 32'h4);
    clr <= 1'b0;
    apb(1'b1, ra(1, 2), 32'h1);
    repeat (24) begin
      bypIn <= ~bypIn;
      repeat (4) @(posedge clk);
    end
    chk("one-shot high", 32'h8, {16'h0, fsHi});
    chk("one-shot low", 32'h10, {16'h0, fsLo});
    apb(1'b1, ra(0, 1), 32'h80000000);
    apb(1'b1, ra(0, 0), 32'h80000000);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, ra(0, 3), k ? 32'h1c0 : 32'h0);
      extSrc <= 4'hf;
      repeat (8) @(posedge clk);
      chk("external clock", {31'h0, k == 0}, {31'h0, sck[0]});
      extSrc <= 4'h0;
      repeat (8) @(posedge clk);
    end
    apb(1'b1, ra(2, 3), 32'h1);
    apb(1'b1, ra(2, 1), 32'h4);
    apb(1'b1, ra(2, 0), 32'hc0000004);
    for (int k = 0; k < 2; k++) begin
      seen = 1'b0;
      extTrig <= {4{k[0]}};
      repeat (24) begin
        @(posedge clk);
        seen = seen | fs[2];
      end
      chk("trigger gate", {31'h0, k[0]}, {31'h0, seen});
    end
    // reset in mid-run clears registers and outputs
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset outputs", 32'h0, {24'h0, sck, fs});
    apb(1'b0, ra(2, 0), 32'h0);
    chk("reset again", 32'h0, rd);
    final_report();
  end
endmodule // sfg_generator_tb
`default_nettype wire

/* File: test/sfg_port_model.sv */
// port model: serial port consuming one unit's bit clock and frame sync
// assumes both inputs change only just after rising edges of clk
`timescale 1ns/1ps
`default_nettype none
module sfg_port_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic sck,
  input wire logic fs,
  output logic [15:0] sckHi,
  output logic [15:0] sckLo,
  output logic [15:0] fsHi,
  output logic [15:0] fsLo,
  output logic together
);
  ////////////////////////////////////////////////////////////////////////////
  // listener only, drives nothing back; lengths in clk cycles
  logic sckD, fsD;
  logic [15:0] sckN, fsN;
  always @(posedge clk) begin
    sckD <= sck;
    fsD <= fs;
    sckN <= (sck != sckD) ? 16'h1 : sckN + 16'h1;
    fsN <= (fs != fsD) ? 16'h1 : fsN + 16'h1;
    // cleared per scenario so a coincidence cannot carry over to the next
    if (clr) begin
      sckHi <= 16'h0;
      sckLo <= 16'h0;
      fsHi <= 16'h0;
      fsLo <= 16'h0;
      together <= 1'b0;
    end else begin
      if (sck != sckD) begin
        if (sck) sckLo <= sckN;
        else sckHi <= sckN;
      end
      if (fs != fsD) begin
        if (fs) fsLo <= fsN;
        else fsHi <= fsN;
      end
      together <= (sck & !sckD & fs & !fsD) | together;
    end
  end
endmodule // sfg_port_model
`default_nettype wire
